// ===== hw/usb_ep_pkg.sv
// constants and carrier types for the usb endpoint 1..5 control/status block
// assumes one 20 MHz clock and an axi4-lite master on the register side
package usb_ep_pkg;

   localparam int ADDR_W = 20;
   localparam int IDX_W  = 18;
   localparam int EP_LO  = 1;
   localparam int EP_HI  = 5;
   localparam int IRQ_W  = 10;
   localparam int IRQ_OUT_BASE = 5;

   // register indexes; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_IN_CTL_HIGH  = 18'h0_de12;
   localparam logic [IDX_W-1:0] IDX_OUT_MAX      = 18'h0_de13;
   localparam logic [IDX_W-1:0] IDX_OUT_STAT_LOW = 18'h0_de14;
   localparam logic [IDX_W-1:0] IDX_EP_INDEX     = 18'h0_de30;
   localparam logic [IDX_W-1:0] IDX_IN_MAX       = 18'h0_de31;
   localparam logic [IDX_W-1:0] IDX_IN_STAT_LOW  = 18'h0_de32;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT     = 18'h0_de33;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR      = 18'h0_de34;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN       = 18'h0_de35;

   // in control high fields
   localparam int IHB_AUTO   = 7;
   localparam int IHB_ISO    = 6;
   localparam int IHB_RSV_HI = 5;
   localparam int IHB_RSV_LO = 4;
   localparam int IHB_FORCE  = 3;
   localparam int IHB_DBL    = 0;
   localparam logic [1:0] RSV_RESET = 2'h2;

   // out control/status low fields
   localparam int OLB_TOG_RST    = 7;
   localparam int OLB_STALL_SENT = 6;
   localparam int OLB_STALL_REQ  = 5;
   localparam int OLB_FLUSH      = 4;
   localparam int OLB_ERR        = 3;
   localparam int OLB_OVR        = 2;
   localparam int OLB_FULL       = 1;
   localparam int OLB_READY      = 0;
   localparam int ISL_READY      = 0;

   localparam logic [7:0] OUT_MAX_RESET = 8'h00;
   localparam logic [2:0] SIZE_UNIT_ZEROS = 3'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [EP_HI:EP_LO]       ep_vec_t;
   typedef logic [EP_HI:EP_LO][7:0]  ep_byte_t;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_t;

   typedef struct packed {
      logic             wr;
      logic [IDX_W-1:0] widx;
      logic [15:0]      wdata;
      logic [1:0]       wstrb;
   } reg_acc_t;

   typedef struct packed {
      logic       in_wr;
      logic [2:0] in_wr_ep;
      logic       in_done;
      logic [2:0] in_done_ep;
      logic       in_ack;
      logic       out_rx;
      logic [2:0] out_rx_ep;
      logic       out_crc_err;
      logic       out_lost;
      logic [2:0] out_lost_ep;
      logic       out_stall_tx;
      logic [2:0] out_stall_ep;
      ep_vec_t    out_full;
   } usb_ev_t;

   typedef struct packed {
      ep_vec_t  in_ready;
      ep_vec_t  in_iso;
      ep_vec_t  in_dbl;
      ep_vec_t  in_force;
      ep_vec_t  in_tog;
      ep_vec_t  out_tog;
      ep_vec_t  out_stall_req;
      ep_vec_t  out_flush;
      ep_byte_t in_max;
      ep_byte_t out_max;
   } ep_ctl_t;

   typedef struct packed {
      logic [2:0]                   ep_sel;
      ep_ctl_t                      ctl;
      ep_vec_t                      in_auto;
      logic [EP_HI:EP_LO][1:0]      in_rsv;
      logic [EP_HI:EP_LO][10:0]     in_cnt;
      ep_vec_t                      stall_req;
      ep_vec_t                      stall_sent;
      ep_vec_t                      out_ready;
      ep_vec_t                      out_err;
      ep_vec_t                      out_ovr;
      ep_vec_t                      out_full;
      logic [IRQ_W-1:0]             irq_stat;
      logic [IRQ_W-1:0]             irq_en;
      logic                         irq;
   } main_st_t;

   typedef struct packed {
      logic             aw_held;
      logic             w_held;
      logic [IDX_W-1:0] widx;
      logic [15:0]      wdata;
      logic [1:0]       wstrb;
      axi_rsp_t         rsp;
   } bus_st_t;

   function automatic logic ep_ok(input logic [2:0] e);
      return (e >= 3'(EP_LO)) && (e <= 3'(EP_HI));
   endfunction

endpackage

// ===== hw/reg_bus_slave.sv
// axi4-lite slave front end: holds address and data, issues one write
// strobe and answers; assumes the register file decodes hits combinationally
`timescale 1ns/10ps
module reg_bus_slave
(
   input  wire logic                              aclk,
   input  wire logic                              aresetn,
   input  wire usb_ep_pkg::axi_req_t              req,
   output usb_ep_pkg::axi_rsp_t                   rsp,
   output usb_ep_pkg::reg_acc_t                   acc,
   output logic [usb_ep_pkg::IDX_W-1:0]           ridx,
   input  wire logic [15:0]                       rd_data,
   input  wire logic                              rd_hit,
   input  wire logic                              wr_hit
);

   usb_ep_pkg::bus_st_t s_ff;
   usb_ep_pkg::bus_st_t nxt_s;
   logic                fire;

   assign fire      = s_ff.aw_held && s_ff.w_held && !s_ff.rsp.bvalid;
   assign rsp       = s_ff.rsp;
   assign ridx      = req.araddr[usb_ep_pkg::ADDR_W-1:2];
   assign acc.wr    = fire && wr_hit;
   assign acc.widx  = s_ff.widx;
   assign acc.wdata = s_ff.wdata;
   assign acc.wstrb = s_ff.wstrb;

   always_comb
   begin
      nxt_s = s_ff;
      if (req.awvalid && s_ff.rsp.awready)
      begin
         nxt_s.aw_held = 1'b1;
         nxt_s.widx    = req.awaddr[usb_ep_pkg::ADDR_W-1:2];
      end
      if (req.wvalid && s_ff.rsp.wready)
      begin
         nxt_s.w_held = 1'b1;
         nxt_s.wdata  = req.wdata[15:0];
         nxt_s.wstrb  = req.wstrb[1:0];
      end
      if (s_ff.rsp.bvalid && req.bready)
         nxt_s.rsp.bvalid = 1'b0;
      if (fire)
      begin
         nxt_s.rsp.bvalid = 1'b1;
         nxt_s.rsp.bresp  = wr_hit ? usb_ep_pkg::RESP_OKAY
                                   : usb_ep_pkg::RESP_SLVERR;
         nxt_s.aw_held    = 1'b0;
         nxt_s.w_held     = 1'b0;
      end
      if (s_ff.rsp.rvalid && req.rready)
         nxt_s.rsp.rvalid = 1'b0;
      if (req.arvalid && s_ff.rsp.arready)
      begin
         nxt_s.rsp.rvalid = 1'b1;
         nxt_s.rsp.rdata  = {16'h0000, rd_data};
         nxt_s.rsp.rresp  = rd_hit ? usb_ep_pkg::RESP_OKAY
                                   : usb_ep_pkg::RESP_SLVERR;
      end
      // readies come from flops: each opens only when its own channel holds nothing and owes no response
      nxt_s.rsp.awready = !nxt_s.aw_held && !nxt_s.rsp.bvalid;
      nxt_s.rsp.wready  = !nxt_s.w_held && !nxt_s.rsp.bvalid;
      nxt_s.rsp.arready = !nxt_s.rsp.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

endmodule

// ===== hw/usb_ep_ctrl.sv
// control and status for usb endpoints 1..5: in high controls, out max
// size, out low status, interrupt status/clear/enable, axi4-lite registers
// assumes the usb engine drives ev on aclk and owns the fifos
//
// Overview of operation
// - with auto-ready set, a full max-size in packet raises in packet-ready
// - in type bit: 0 bulk/interrupt, 1 isochronous, per selected endpoint
// - forced toggle switches in toggle and drops the packet regardless
// - in double-buffer bit: 0 disables, 1 enables double buffering
// - out max size is 8 bits in 8-byte units for selected endpoint
// - toggle-reset write sets out toggle to data0 and self-clears
// - stall sent sets a flag and interrupt; firmware clears it
// - stall request stalls out tokens only on bulk/interrupt endpoints
// - flush drops next out packet, clears packet-ready, self-clears
// - iso crc or stuff error sets data-error; cleared with packet-ready
// - iso out packet without room sets overrun; firmware clears it
// - read-only fifo-full shows out fifo cannot take another packet
// - received out packet sets packet-ready and requests interrupt
// - firmware sets in packet-ready; device clears it when sent, interrupt
`timescale 1ns/10ps
module usb_ep_ctrl
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire usb_ep_pkg::axi_req_t  bus_req,
   output usb_ep_pkg::axi_rsp_t       bus_rsp,
   input  wire usb_ep_pkg::usb_ev_t   ev,
   input  wire usb_ep_pkg::ep_vec_t   out_iso,
   output usb_ep_pkg::ep_ctl_t        ctl,
   output logic                       irq
);

   usb_ep_pkg::main_st_t             s_ff;
   usb_ep_pkg::main_st_t             nxt_s;
   usb_ep_pkg::reg_acc_t             acc;
   logic [usb_ep_pkg::IDX_W-1:0]     ridx;
   logic [15:0]                      rd_data;
   logic                             rd_hit;
   logic                             wr_hit;
   logic                             auto_hit;
   logic [15:0]                      wmask;
   logic [7:0]                       d;
   logic [2:0]                       e;
   logic                             sel_ok;

   function automatic logic reg_hit(input logic [usb_ep_pkg::IDX_W-1:0] ix);
      return ix == usb_ep_pkg::IDX_IN_CTL_HIGH  ||
             ix == usb_ep_pkg::IDX_OUT_MAX      ||
             ix == usb_ep_pkg::IDX_OUT_STAT_LOW ||
             ix == usb_ep_pkg::IDX_EP_INDEX     ||
             ix == usb_ep_pkg::IDX_IN_MAX       ||
             ix == usb_ep_pkg::IDX_IN_STAT_LOW  ||
             ix == usb_ep_pkg::IDX_IRQ_STAT     ||
             ix == usb_ep_pkg::IDX_IRQ_CLR      ||
             ix == usb_ep_pkg::IDX_IRQ_EN;
   endfunction

   reg_bus_slave u_bus
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .req     (bus_req),
      .rsp     (bus_rsp),
      .acc     (acc),
      .ridx    (ridx),
      .rd_data (rd_data),
      .rd_hit  (rd_hit),
      .wr_hit  (wr_hit)
   );

   assign wr_hit = reg_hit(acc.widx);
   assign rd_hit = reg_hit(ridx);
   assign ctl    = s_ff.ctl;
   assign irq    = s_ff.irq;
   assign e      = s_ff.ep_sel;
   assign sel_ok = usb_ep_pkg::ep_ok(s_ff.ep_sel);
   assign d      = acc.wdata[7:0];
   assign wmask  = {{8{acc.wstrb[1]}}, {8{acc.wstrb[0]}}};

   // read side: registers of the selected endpoint, zero when none selected
   always_comb
   begin
      rd_data = 16'h0000;
      unique case (ridx)
         usb_ep_pkg::IDX_EP_INDEX:
            rd_data = {13'h0000, s_ff.ep_sel};
         usb_ep_pkg::IDX_IN_CTL_HIGH:
            if (sel_ok)
               rd_data = {8'h00, s_ff.in_auto[e], s_ff.ctl.in_iso[e],
                          s_ff.in_rsv[e], s_ff.ctl.in_force[e], 2'h0,
                          s_ff.ctl.in_dbl[e]};
         usb_ep_pkg::IDX_OUT_MAX:
            if (sel_ok)
               rd_data = {8'h00, s_ff.ctl.out_max[e]};
         usb_ep_pkg::IDX_IN_MAX:
            if (sel_ok)
               rd_data = {8'h00, s_ff.ctl.in_max[e]};
         usb_ep_pkg::IDX_IN_STAT_LOW:
            if (sel_ok)
               rd_data = {15'h0000, s_ff.ctl.in_ready[e]};
         usb_ep_pkg::IDX_OUT_STAT_LOW:
            if (sel_ok)
               rd_data = {8'h00, 1'b0, s_ff.stall_sent[e],
                          s_ff.stall_req[e], 1'b0, s_ff.out_err[e],
                          s_ff.out_ovr[e], s_ff.out_full[e],
                          s_ff.out_ready[e]};
         usb_ep_pkg::IDX_IRQ_STAT:
            rd_data = {6'h00, s_ff.irq_stat};
         usb_ep_pkg::IDX_IRQ_EN:
            rd_data = {6'h00, s_ff.irq_en};
         default:
            rd_data = 16'h0000;
      endcase
   end

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.ctl.out_flush = '0;
      auto_hit = 1'b0;
      // firmware writes first, so engine events below win over clears
      if (acc.wr && acc.widx == usb_ep_pkg::IDX_EP_INDEX && acc.wstrb[0])
         nxt_s.ep_sel = d[2:0];
      if (acc.wr && acc.wstrb[0] && sel_ok)
      begin
         unique case (acc.widx)
            usb_ep_pkg::IDX_IN_CTL_HIGH:
            begin
               nxt_s.in_auto[e]      = d[usb_ep_pkg::IHB_AUTO];
               nxt_s.ctl.in_iso[e]   = d[usb_ep_pkg::IHB_ISO];
               nxt_s.in_rsv[e]       = d[usb_ep_pkg::IHB_RSV_HI:
                                         usb_ep_pkg::IHB_RSV_LO];
               nxt_s.ctl.in_force[e] = d[usb_ep_pkg::IHB_FORCE];
               nxt_s.ctl.in_dbl[e]   = d[usb_ep_pkg::IHB_DBL];
            end
            usb_ep_pkg::IDX_OUT_MAX:
               nxt_s.ctl.out_max[e] = d;
            usb_ep_pkg::IDX_IN_MAX:
               nxt_s.ctl.in_max[e] = d;
            usb_ep_pkg::IDX_IN_STAT_LOW:
               if (d[usb_ep_pkg::ISL_READY])
               begin
                  nxt_s.ctl.in_ready[e] = 1'b1;
                  nxt_s.in_cnt[e]       = 11'h000;
               end
            usb_ep_pkg::IDX_OUT_STAT_LOW:
            begin
               if (d[usb_ep_pkg::OLB_TOG_RST])
                  nxt_s.ctl.out_tog[e] = 1'b0;
               nxt_s.stall_sent[e] = d[usb_ep_pkg::OLB_STALL_SENT];
               nxt_s.stall_req[e]  = d[usb_ep_pkg::OLB_STALL_REQ];
               nxt_s.out_ovr[e]    = d[usb_ep_pkg::OLB_OVR];
               if (d[usb_ep_pkg::OLB_FLUSH])
               begin
                  nxt_s.ctl.out_flush[e] = 1'b1;
                  nxt_s.out_ready[e]     = 1'b0;
                  nxt_s.out_err[e]       = 1'b0;
               end
               else if (!d[usb_ep_pkg::OLB_READY])
               begin
                  nxt_s.out_ready[e] = 1'b0;
                  nxt_s.out_err[e]   = 1'b0;
               end
            end
            default:
               nxt_s.ep_sel = nxt_s.ep_sel;
         endcase
      end
      if (acc.wr && acc.widx == usb_ep_pkg::IDX_IRQ_CLR)
         nxt_s.irq_stat = s_ff.irq_stat & ~(acc.wdata[9:0] & wmask[9:0]);
      if (acc.wr && acc.widx == usb_ep_pkg::IDX_IRQ_EN)
         nxt_s.irq_en = (s_ff.irq_en & ~wmask[9:0]) |
                        (acc.wdata[9:0] & wmask[9:0]);

      // engine events
      if (ev.in_wr && usb_ep_pkg::ep_ok(ev.in_wr_ep))
      begin
         nxt_s.in_cnt[ev.in_wr_ep] = 11'(s_ff.in_cnt[ev.in_wr_ep] + 11'h001);
         if (s_ff.in_auto[ev.in_wr_ep] &&
             s_ff.ctl.in_max[ev.in_wr_ep] != 8'h00 &&
             nxt_s.in_cnt[ev.in_wr_ep] >= {s_ff.ctl.in_max[ev.in_wr_ep],
                                           usb_ep_pkg::SIZE_UNIT_ZEROS})
         begin
            nxt_s.ctl.in_ready[ev.in_wr_ep] = 1'b1;
            nxt_s.in_cnt[ev.in_wr_ep]       = 11'h000;
            auto_hit                        = 1'b1;
         end
      end
      if (ev.in_done && usb_ep_pkg::ep_ok(ev.in_done_ep) &&
          (ev.in_ack || s_ff.ctl.in_force[ev.in_done_ep]))
      begin
         // forced toggle drops the packet and flips even without a good ack
         nxt_s.ctl.in_tog[ev.in_done_ep]   = ~s_ff.ctl.in_tog[ev.in_done_ep];
         nxt_s.ctl.in_ready[ev.in_done_ep] = 1'b0;
         nxt_s.irq_stat[ev.in_done_ep - 3'(usb_ep_pkg::EP_LO)] = 1'b1;
      end
      if (ev.out_rx && usb_ep_pkg::ep_ok(ev.out_rx_ep))
      begin
         nxt_s.out_ready[ev.out_rx_ep]   = 1'b1;
         nxt_s.ctl.out_tog[ev.out_rx_ep] = ~s_ff.ctl.out_tog[ev.out_rx_ep];
         nxt_s.out_err[ev.out_rx_ep] = out_iso[ev.out_rx_ep] &&
                                       ev.out_crc_err;
         nxt_s.irq_stat[usb_ep_pkg::IRQ_OUT_BASE - usb_ep_pkg::EP_LO +
                        int'(ev.out_rx_ep)] = 1'b1;
      end
      if (ev.out_lost && usb_ep_pkg::ep_ok(ev.out_lost_ep) &&
          out_iso[ev.out_lost_ep])
         nxt_s.out_ovr[ev.out_lost_ep] = 1'b1;
      if (ev.out_stall_tx && usb_ep_pkg::ep_ok(ev.out_stall_ep))
      begin
         nxt_s.stall_sent[ev.out_stall_ep] = 1'b1;
         nxt_s.irq_stat[usb_ep_pkg::IRQ_OUT_BASE - usb_ep_pkg::EP_LO +
                        int'(ev.out_stall_ep)] = 1'b1;
      end
      nxt_s.out_full          = ev.out_full;
      nxt_s.ctl.out_stall_req = nxt_s.stall_req & ~out_iso;
      nxt_s.irq               = |(nxt_s.irq_stat & nxt_s.irq_en);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_ff        <= '0;
         s_ff.in_rsv <= {5{usb_ep_pkg::RSV_RESET}};
         s_ff.ctl.out_max <= {5{usb_ep_pkg::OUT_MAX_RESET}};
      end
      else
         s_ff <= nxt_s;
   end

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic out_wr_sel;
   assign out_wr_sel = acc.wr && acc.wstrb[0] && sel_ok &&
                       acc.widx == usb_ep_pkg::IDX_OUT_STAT_LOW;

   auto_ready_set_a: assert property (
      auto_hit |=> s_ff.ctl.in_ready[$past(ev.in_wr_ep)] &&
                   s_ff.in_cnt[$past(ev.in_wr_ep)] == 11'h000)
      else $error("auto ready not raised on full packet");

   toggle_reset_a: assert property (
      out_wr_sel && d[usb_ep_pkg::OLB_TOG_RST] &&
      !(ev.out_rx && ev.out_rx_ep == e)
      |=> !s_ff.ctl.out_tog[$past(e)])
      else $error("out toggle not reset to data0");

   stall_sent_a: assert property (
      ev.out_stall_tx && usb_ep_pkg::ep_ok(ev.out_stall_ep)
      |=> s_ff.stall_sent[$past(ev.out_stall_ep)] &&
          s_ff.irq_stat[usb_ep_pkg::IRQ_OUT_BASE - usb_ep_pkg::EP_LO +
                        int'($past(ev.out_stall_ep))])
      else $error("stall sent flag missing");

   stall_iso_gate_a: assert property (
      (s_ff.ctl.out_stall_req & $past(out_iso)) == '0)
      else $error("stall offered on isochronous out endpoint");

   flush_clears_a: assert property (
      out_wr_sel && d[usb_ep_pkg::OLB_FLUSH] &&
      !(ev.out_rx && ev.out_rx_ep == e)
      |=> !s_ff.out_ready[$past(e)] && s_ff.ctl.out_flush[$past(e)]
      ##1 s_ff.ctl.out_flush == '0)
      else $error("flush did not drop ready or self-clear");

   err_with_ready_a: assert property (
      (s_ff.out_err & ~s_ff.out_ready) == '0)
      else $error("data error outlives packet ready");

   overrun_set_a: assert property (
      ev.out_lost && usb_ep_pkg::ep_ok(ev.out_lost_ep) &&
      out_iso[ev.out_lost_ep] |=> s_ff.out_ovr[$past(ev.out_lost_ep)])
      else $error("overrun not flagged");

   fifo_full_a: assert property (
      s_ff.out_full == $past(ev.out_full))
      else $error("fifo full does not follow engine");

   rx_ready_a: assert property (
      ev.out_rx && usb_ep_pkg::ep_ok(ev.out_rx_ep)
      |=> s_ff.out_ready[$past(ev.out_rx_ep)] &&
          s_ff.irq_stat[usb_ep_pkg::IRQ_OUT_BASE - usb_ep_pkg::EP_LO +
                        int'($past(ev.out_rx_ep))])
      else $error("received packet not flagged");

   in_sent_a: assert property (
      ev.in_done && ev.in_ack && usb_ep_pkg::ep_ok(ev.in_done_ep) &&
      !(acc.wr && acc.widx == usb_ep_pkg::IDX_IN_STAT_LOW)
      |=> !s_ff.ctl.in_ready[$past(ev.in_done_ep)])
      else $error("in packet ready not cleared after send");

   irq_level_a: assert property (
      ev.in_done && ev.in_ack && usb_ep_pkg::ep_ok(ev.in_done_ep) &&
      s_ff.irq_en[ev.in_done_ep - 3'(usb_ep_pkg::EP_LO)] &&
      !(acc.wr && acc.widx == usb_ep_pkg::IDX_IRQ_EN) |=> s_ff.irq)
      else $error("interrupt level wrong");

   auto_fire_c: cover property (auto_hit ##1 s_ff.irq == 1'b0);
   flush_c:     cover property (out_wr_sel && d[usb_ep_pkg::OLB_FLUSH]);
   stall_c:     cover property (ev.out_stall_tx ##1 s_ff.irq);
   iso_err_c:   cover property (s_ff.out_err != '0);

endmodule

// ===== sim/usb_host_model.sv
// usb engine stand-in: one-cycle endpoint event pulses, fifo-full levels
// assumes the control block samples ev on the same aclk
`timescale 1ns/10ps
module usb_host_model
(
   input  wire logic                aclk,
   input  wire usb_ep_pkg::ep_vec_t full,
   output usb_ep_pkg::usb_ev_t      ev
);
   usb_ep_pkg::usb_ev_t p = '0;
   always_comb
   begin
      ev = p;
      ev.out_full = full;
   end
   // k: 0 out rx, 1 out lost, 2 stall sent, 3 in byte, 4 in sent
   task automatic evt(input int k, input logic [2:0] e, input logic f);
      usb_ep_pkg::usb_ev_t v;
      v = '0;
      v.out_rx = k == 0;
      v.out_crc_err = f;
      v.out_lost = k == 1;
      v.out_stall_tx = k == 2;
      v.in_wr = k == 3;
      v.in_done = k == 4;
      v.in_ack = f;
      v.out_rx_ep = e;
      v.out_lost_ep = e;
      v.out_stall_ep = e;
      v.in_wr_ep = e;
      v.in_done_ep = e;
      @(posedge aclk);
      p <= v;
      @(posedge aclk);
      p <= '0;
   endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for usb_ep_ctrl: axi4-lite master and engine model
// assumes the register indexes and timing of the package
`timescale 1ns/10ps
module testbench;
   logic                 aclk = 1'b0;
   logic                 aresetn;
   usb_ep_pkg::axi_req_t req;
   usb_ep_pkg::axi_rsp_t rsp;
   usb_ep_pkg::usb_ev_t  ev;
   usb_ep_pkg::ep_vec_t  iso;
   usb_ep_pkg::ep_vec_t  full;
   usb_ep_pkg::ep_ctl_t  ctl;
   logic                 irq;
   logic [31:0]          d;
   logic [31:0]          seed;
   logic [1:0]           r;
   logic [7:0]           m [1:5];
   int                   n_fail = 0;
   int                   tests_run = 0;

   usb_ep_ctrl usb_ep_ctrl_i (.aclk(aclk), .aresetn(aresetn), .bus_req(req),
      .bus_rsp(rsp), .ev(ev), .out_iso(iso), .ctl(ctl), .irq(irq));
   usb_host_model usb_host_model_i (.aclk(aclk), .full(full), .ev(ev));

   initial
   begin
      forever #25 aclk = ~aclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected in control high word, reserved field always 10
   function automatic logic [31:0] high(input logic a, i, f, b);
      return {24'h0, a, i, usb_ep_pkg::RSV_RESET, f, 2'b00, b};
   endfunction

   task automatic chk(input logic [31:0] got, exp, input string s);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t %s: got %h want %h", $time, s, got, exp);
      end
   endtask

   task automatic wr(input logic [17:0] a, input logic [31:0] v);
      @(posedge aclk);
      req.awaddr <= {a, 2'b00};
      req.wdata <= v;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      r = rsp.bresp;
      req.bready <= 1'b0;
   endtask

   task automatic rc(input logic [17:0] a, input logic [31:0] x, string s);
      @(posedge aclk);
      req.araddr <= {a, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
      chk(d, x, s);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      finish_test;
   end

   initial
   begin
      req = '0;
      iso = '0;
      full = '0;
      aresetn = 1'b0;
      seed = 32'he73f_b567;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      wr(usb_ep_pkg::IDX_EP_INDEX, 32'h1);
      rc(usb_ep_pkg::IDX_IN_CTL_HIGH, high(0, 0, 0, 0), "high rst");
      rc(usb_ep_pkg::IDX_OUT_MAX, 32'h0, "max rst");
      rc(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h0, "low rst");
      rc(18'h0_de20, 32'h0, "unmapped");
      chk(r, usb_ep_pkg::RESP_SLVERR, "unmapped resp");
      for (int e = 1; e <= 5; e++)
      begin
         seed = lfsr(seed);
         m[e] = (e == 5) ? 8'h08 : {5'h00, seed[2:0]};
         wr(usb_ep_pkg::IDX_EP_INDEX, 32'(e));
         wr(usb_ep_pkg::IDX_OUT_MAX, {24'h0, m[e]});
         wr(usb_ep_pkg::IDX_IN_CTL_HIGH, high(0, seed[8], 0, seed[9]));
         chk(ctl.in_iso[e], seed[8], "iso");
         chk(ctl.in_dbl[e], seed[9], "dbl");
      end
      for (int e = 1; e <= 5; e++)
      begin
         wr(usb_ep_pkg::IDX_EP_INDEX, 32'(e));
         rc(usb_ep_pkg::IDX_OUT_MAX, {24'h0, m[e]}, "max");
         chk(ctl.out_max[e], m[e], "max out");
      end
      $display("test registers done");
      wr(usb_ep_pkg::IDX_EP_INDEX, 32'h2);
      wr(usb_ep_pkg::IDX_IRQ_EN, 32'h0000_03ff);
      usb_host_model_i.evt(0, 3'h2, 1'b0);
      @(posedge aclk);
      chk(irq, 1, "rx irq");
      chk(ctl.out_tog[2], 1, "rx tog");
      rc(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h01, "ready");
      wr(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h80);
      chk(ctl.out_tog[2], 0, "tog reset");
      rc(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h0, "tog bit");
      wr(usb_ep_pkg::IDX_IRQ_CLR, 32'h0000_03ff);
      chk(irq, 0, "irq clr");
      usb_host_model_i.evt(0, 3'h2, 1'b0);
      wr(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h11);
      rc(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h0, "flush");
      $display("test out done");
      wr(usb_ep_pkg::IDX_EP_INDEX, 32'h3);
      wr(usb_ep_pkg::IDX_IRQ_CLR, 32'h0000_03ff);
      wr(usb_ep_pkg::IDX_IRQ_EN, 32'h0);
      usb_host_model_i.evt(2, 3'h3, 1'b0);
      @(posedge aclk);
      chk(irq, 0, "masked");
      rc(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h40, "stall sent");
      rc(usb_ep_pkg::IDX_IRQ_STAT, 32'h80, "stall stat");
      wr(usb_ep_pkg::IDX_IRQ_EN, 32'h0000_03ff);
      chk(irq, 1, "unmasked");
      wr(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h20);
      chk(ctl.out_stall_req[3], 1, "stall req");
      iso[3] <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(ctl.out_stall_req[3], 0, "iso stall");
      usb_host_model_i.evt(0, 3'h3, 1'b1);
      usb_host_model_i.evt(1, 3'h3, 1'b0);
      full[3] <= 1'b1;
      rc(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h2f, "iso");
      wr(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h20);
      rc(usb_ep_pkg::IDX_OUT_STAT_LOW, 32'h22, "err clr");
      $display("test stall done");
      wr(usb_ep_pkg::IDX_EP_INDEX, 32'h4);
      wr(usb_ep_pkg::IDX_IN_MAX, 32'h1);
      chk(ctl.in_max[4], 1, "in max");
      wr(usb_ep_pkg::IDX_IN_CTL_HIGH, high(1, 0, 0, 0));
      repeat (7) usb_host_model_i.evt(3, 3'h4, 1'b0);
      @(posedge aclk);
      chk(ctl.in_ready[4], 0, "7 bytes");
      usb_host_model_i.evt(3, 3'h4, 1'b0);
      @(posedge aclk);
      chk(ctl.in_ready[4], 1, "auto");
      wr(usb_ep_pkg::IDX_IRQ_CLR, 32'h0000_03ff);
      usb_host_model_i.evt(4, 3'h4, 1'b1);
      @(posedge aclk);
      chk(ctl.in_ready[4], 0, "sent");
      chk(irq, 1, "in irq");
      chk(ctl.in_tog[4], 1, "ack tog");
      wr(usb_ep_pkg::IDX_IN_STAT_LOW, 32'h1);
      wr(usb_ep_pkg::IDX_IN_CTL_HIGH, high(1, 0, 1, 0));
      chk(ctl.in_force[4], 1, "force bit");
      usb_host_model_i.evt(4, 3'h4, 1'b0);
      @(posedge aclk);
      chk(ctl.in_ready[4], 0, "force drop");
      chk(ctl.in_tog[4], 0, "force tog");
      $display("test in done");
      finish_test;
   end
endmodule
